// *** dv/cecnt_unit_tb.sv ***
// self-checking bench for cecnt_unit: indexed reads and writes, dedicated reads, faults
// assumes a one-cycle answer after the taking edge and inputs driven 1 ns after each edge
`timescale 1ns/1ps
module cecnt_unit_tb;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         en  = 1'b1;
	logic         vld = 1'b0;
	logic [15:0]  opc = 16'h0;
	logic [31:0]  idx = 32'h0;
	logic [31:0]  shi = 32'h0;
	logic [31:0]  slo = 32'h0;
	logic [1:0]   pl  = 2'h0;
	logic         rsr = 1'b0;
	logic         counter_read_enable_flag = 1'b0;
	logic [255:0] hit = '0;
	logic [31:0]  rh, rl, td, ta, tc;
	logic         rv, pf;
	logic [63:0]  r, a;
	logic [1:0]   fl;
	logic [31:0]  ctl;
	int           fail_count = 0;
	int           compares = 0;
	int           cyc = 0;

	cecnt_unit cecnt_unit_i (.MCLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en), .INSTR_VALID_I(vld),
		.OPCODE_I(opc), .INDEX_I(idx), .SRC_HIGH_I(shi), .SRC_LOW_I(slo), .PRIV_LEVEL_I(pl),
		.STAMP_RESTRICT_I(rsr), .COUNTER_READ_ENABLE_I(counter_read_enable_flag), .EVENT_HIT_I(hit),
		.RESULT_HIGH_O(rh), .RESULT_LOW_O(rl), .RESULT_VALID_O(rv), .PROT_FAULT_O(pf),
		.TEST_DATA_O(td), .TEST_ADDRESS_O(ta), .TEST_CMD_STATUS_O(tc));

	always #2 clk = ~clk;

	task automatic end_sim();
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one instruction: held for its taking edge, answer sampled 1 ns later while the
	// one-cycle pulses still stand, then an idle edge so valid never toggles in one step
	task automatic op(input logic [15:0] o, input logic [31:0] i, input logic [63:0] s,
		input logic [1:0] p);
		opc = o;
		idx = i;
		{shi, slo} = s;
		pl = p;
		vld = 1'b1;
		@(posedge clk);
		#1 r = {rh, rl};
		fl = {rv, pf};
		vld = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic fcase(input logic [15:0] o, input logic [1:0] p, input logic s,
		input logic e, input logic f);
		rsr = s;
		counter_read_enable_flag = e;
		op(o, cecnt_pkg::IDX_TEST_DATA, 64'hFFFF_FFFF_FFFF_FFFF, p);
		chk("answer flags", {62'h0, fl}, f ? 64'h1 : 64'h2);
	endtask

	task automatic pair_diff(input logic [31:0] n, input logic [1:0] p);
		op(cecnt_pkg::OPC_COUNTER_READ, n, 64'h0, p);
		a = r;
		op(cecnt_pkg::OPC_COUNTER_READ, n, 64'h0, p);
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		chk("reset result", {rh, rl}, 64'h0);
		chk("reset flags", {62'h0, rv, pf}, 64'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_EVENT_CONTROL, 64'h0, 2'h0);
		chk("control reset", r, 64'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_CYCLE_STAMP, 64'h0, 2'h0);
		a = r;
		op(cecnt_pkg::OPC_STAMP_READ, 32'h0, 64'h0, 2'h3);
		chk("stamp step", r, a + 64'h2);
		a = r;
		en = 1'b0;
		repeat (4) @(posedge clk);
		#1 en = 1'b1;
		op(cecnt_pkg::OPC_STAMP_READ, 32'h0, 64'h0, 2'h0);
		chk("enable freeze", r, a + 64'h2);
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_CYCLE_STAMP, 64'h0123_4567_89AB_CDEF, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_CYCLE_STAMP, 64'h0, 2'h0);
		chk("stamp write", r, 64'h0123_4567_89AB_CDF0);
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_CYCLE_STAMP, 64'hFFFF_FFFF_FFFF_FFFF, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_CYCLE_STAMP, 64'h0, 2'h0);
		chk("stamp wrap", r, 64'h0);
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_EVENT_CONTROL, 64'hFFFF_FFFF_FFFF_FFFF, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_EVENT_CONTROL, 64'h0, 2'h0);
		chk("control mask", r, 64'h0000_0000_05FF_05FF);
		for (int k = 0; k < 3; k++)
		begin
			op(cecnt_pkg::OPC_MSR_WRITE, 32'h3 + k, {32'h0, 32'hA5A5_0000 + k}, 2'h0);
			op(cecnt_pkg::OPC_MSR_READ, 32'h3 + k, 64'h0, 2'h0);
			chk("test reg", r, {32'h0, 32'hA5A5_0000 + k});
		end
		chk("test outs", {td, ta}, 64'hA5A5_0000_A5A5_0001);
		chk("test cmd out", {32'h0, tc}, 64'hA5A5_0002);
		op(cecnt_pkg::OPC_MSR_WRITE, 32'h20, 64'hFFFF_FFFF_FFFF_FFFF, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, 32'h20, 64'h0, 2'h0);
		chk("unmapped", r, 64'h0);
		// every enable pair, both counters, below-3 and level-3 code
		counter_read_enable_flag = 1'b1;
		for (int n = 0; n < 2; n++)
			for (int m = 0; m < 4; m++)
				for (int l = 1; l < 4; l += 2)
				begin
					ctl = (32'h100 | (m << 6)) << (16 * n);
					op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_EVENT_CONTROL, {32'h0, ctl}, 2'h0);
					pair_diff(n, l[1:0]);
					chk("gated count", r - a, ((l == 3) ? m[1] : m[0]) ? 64'h2 : 64'h0);
				end
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_EVENT_CONTROL, 64'h1C0, 2'h0);
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_PERF_ZERO, 64'h0000_FFFF_FFFF_FFFF, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_PERF_ZERO, 64'h0, 2'h0);
		chk("counter wrap", r, 64'h0);
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_PERF_ONE, 64'h0000_1234_5678_9ABC, 2'h0);
		op(cecnt_pkg::OPC_MSR_READ, cecnt_pkg::IDX_PERF_ONE, 64'h0, 2'h0);
		chk("counter one write", r, 64'h0000_1234_5678_9ABC);
		// event mode on counter zero, event number 5
		op(cecnt_pkg::OPC_MSR_WRITE, cecnt_pkg::IDX_EVENT_CONTROL, 64'h0C5, 2'h0);
		hit[5] = 1'b1;
		pair_diff(32'h0, 2'h0);
		chk("event count", r - a, 64'h2);
		hit[5] = 1'b0;
		hit[6] = 1'b1;
		pair_diff(32'h0, 2'h0);
		chk("other event", r - a, 64'h0);
		hit = '0;
		fcase(cecnt_pkg::OPC_MSR_READ, 2'h1, 1'b0, 1'b1, 1'b1);
		fcase(cecnt_pkg::OPC_MSR_WRITE, 2'h2, 1'b0, 1'b1, 1'b1);
		chk("faulted write", {32'h0, td}, 64'hA5A5_0000);
		fcase(cecnt_pkg::OPC_STAMP_READ, 2'h3, 1'b1, 1'b1, 1'b1);
		fcase(cecnt_pkg::OPC_STAMP_READ, 2'h3, 1'b0, 1'b1, 1'b0);
		fcase(cecnt_pkg::OPC_COUNTER_READ, 2'h1, 1'b0, 1'b0, 1'b1);
		fcase(cecnt_pkg::OPC_COUNTER_READ, 2'h0, 1'b0, 1'b0, 1'b0);
		fcase(cecnt_pkg::OPC_MSR_READ, 2'h0, 1'b1, 1'b0, 1'b0);
		end_sim();
	end
endmodule

// *** rtl/cecnt_pkg.sv ***
// package for the cycle and event counter unit: register indices, field positions, opcodes
// assumes the core pipeline presents one decoded instruction per enabled clock
package cecnt_pkg;
	localparam logic [31:0] IDX_TEST_DATA      = 32'h0000_0003;
	localparam logic [31:0] IDX_TEST_ADDRESS   = 32'h0000_0004;
	localparam logic [31:0] IDX_TEST_CMD_STAT  = 32'h0000_0005;
	localparam logic [31:0] IDX_CYCLE_STAMP    = 32'h0000_0010;
	localparam logic [31:0] IDX_EVENT_CONTROL  = 32'h0000_0011;
	localparam logic [31:0] IDX_PERF_ZERO      = 32'h0000_0012;
	localparam logic [31:0] IDX_PERF_ONE       = 32'h0000_0013;
	localparam logic [15:0] OPC_MSR_WRITE      = 16'h0F30;
	localparam logic [15:0] OPC_STAMP_READ     = 16'h0F31;
	localparam logic [15:0] OPC_MSR_READ       = 16'h0F32;
	localparam logic [15:0] OPC_COUNTER_READ   = 16'h0F33;
	localparam int          CNT_W              = 48;
	localparam int          STAMP_W            = 64;
	localparam int          EVNUM_W            = 7;
	// counter field base: counter n fields sit at FLD_STRIDE*n plus the offsets below
	localparam int          FLD_STRIDE         = 16;
	localparam int          FLD_EVLO           = 0;
	localparam int          FLD_BELOW3         = 6;
	localparam int          FLD_LEVEL3         = 7;
	localparam int          FLD_TYPE           = 8;
	localparam int          FLD_EVHI           = 10;
	localparam logic [31:0] CTRL_WMASK         = 32'h05FF_05FF;
	localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
	localparam logic [1:0]  LEVEL_USER         = 2'h3;
endpackage

// *** rtl/cecnt_unit.sv ***
// cycle stamp counter, two event counters and their control register, reached by
// indexed register read/write instructions and two dedicated read instructions
// assumes the pipeline holds the decoded opcode, index and source pair on INSTR_VALID_I
// Behaviour
// - index register selects the model register
// - register read returns selected value to pair
// - register write loads selected register from pair
// - register access allowed only at level zero
// - 64-bit stamp counts every core cycle
// - stamp keeps counting during suspend
// - stamp read returns full stamp value
// - restrict flag limits stamp read to level0
// - two 48-bit counters under one control
// - counters run through suspend and shutdown
// - counter read returns indexed counter value
// - read-enable flag opens counter read everywhere
// - type bit picks cycles or events
// - level enables gate counting by privilege
// - counter zero fields at bits 10,8,7,6,5:0
// - counter one fields at bits 26,24,23,22,21:16
// - type one means cycles; all zero reset
// - occurrences add one; durations add per cycle
`timescale 1ns/1ps
module cecnt_unit
(
	input  wire logic                 MCLK_I,
	input  wire logic                 SYS_RST_I,
	input  wire logic                 CLK_EN_I,
	input  wire logic                 INSTR_VALID_I,
	input  wire logic [15:0]          OPCODE_I,
	input  wire logic [31:0]          INDEX_I,
	input  wire logic [31:0]          SRC_HIGH_I,
	input  wire logic [31:0]          SRC_LOW_I,
	input  wire logic [1:0]           PRIV_LEVEL_I,
	input  wire logic                 STAMP_RESTRICT_I,
	input  wire logic                 COUNTER_READ_ENABLE_I,
	input  wire logic [255:0]         EVENT_HIT_I,
	output logic [31:0]               RESULT_HIGH_O,
	output logic [31:0]               RESULT_LOW_O,
	output logic                      RESULT_VALID_O,
	output logic                      PROT_FAULT_O,
	output logic [31:0]               TEST_DATA_O,
	output logic [31:0]               TEST_ADDRESS_O,
	output logic [31:0]               TEST_CMD_STATUS_O
);
	// event lines are events of this core clock: occurrence events pulse once per
	// occurrence, duration events stay high per cycle, so one add per high cycle serves both
	logic [63:0]  stamp_q;
	logic [63:0]  stamp_d;
	logic [31:0]  ctrl_q;
	logic [31:0]  tdata_q;
	logic [31:0]  taddr_q;
	logic [31:0]  tcmd_q;
	logic [47:0]  cnt_q [2];
	logic [31:0]  res_hi_q;
	logic [31:0]  res_lo_q;
	logic         res_vld_q;
	logic         fault_q;

	// the event number is split: its top bit sits above the type field
	function automatic logic [6:0] evsel(input logic [31:0] c, input int n);
		evsel = {c[n*cecnt_pkg::FLD_STRIDE+cecnt_pkg::FLD_EVHI],
			c[n*cecnt_pkg::FLD_STRIDE+cecnt_pkg::FLD_EVLO +: 6]};
	endfunction

	wire is_wr     = INSTR_VALID_I && (OPCODE_I == cecnt_pkg::OPC_MSR_WRITE);
	wire is_rd     = INSTR_VALID_I && (OPCODE_I == cecnt_pkg::OPC_MSR_READ);
	wire is_sread  = INSTR_VALID_I && (OPCODE_I == cecnt_pkg::OPC_STAMP_READ);
	wire is_cread  = INSTR_VALID_I && (OPCODE_I == cecnt_pkg::OPC_COUNTER_READ);
	wire lvl0      = (PRIV_LEVEL_I == 2'h0);
	wire lvl3      = (PRIV_LEVEL_I == cecnt_pkg::LEVEL_USER);
	wire msr_ok    = lvl0;
	wire sread_ok  = !STAMP_RESTRICT_I || lvl0;
	wire cread_ok  = COUNTER_READ_ENABLE_I || lvl0;
	wire deny      = ((is_wr || is_rd) && !msr_ok) || (is_sread && !sread_ok)
		|| (is_cread && !cread_ok);
	wire wr_ok     = is_wr && msr_ok;
	wire sel_stamp = (INDEX_I == cecnt_pkg::IDX_CYCLE_STAMP);
	wire sel_ctrl  = (INDEX_I == cecnt_pkg::IDX_EVENT_CONTROL);
	wire sel_c0    = (INDEX_I == cecnt_pkg::IDX_PERF_ZERO);
	wire sel_c1    = (INDEX_I == cecnt_pkg::IDX_PERF_ONE);
	wire sel_td    = (INDEX_I == cecnt_pkg::IDX_TEST_DATA);
	wire sel_ta    = (INDEX_I == cecnt_pkg::IDX_TEST_ADDRESS);
	wire sel_tc    = (INDEX_I == cecnt_pkg::IDX_TEST_CMD_STAT);
	wire [63:0] wdata = {SRC_HIGH_I, SRC_LOW_I};
	wire [63:0] c0_ext = {16'h0000, cnt_q[0]};
	wire [63:0] c1_ext = {16'h0000, cnt_q[1]};
	// counter read uses index bit 0 to pick the counter
	wire [63:0] cread_val = INDEX_I[0] ? c1_ext : c0_ext;
	wire [63:0] msr_val =
		sel_stamp ? stamp_q :
		sel_ctrl  ? {32'h0000_0000, ctrl_q} :
		sel_c0    ? c0_ext :
		sel_c1    ? c1_ext :
		sel_td    ? {32'h0000_0000, tdata_q} :
		sel_ta    ? {32'h0000_0000, taddr_q} :
		sel_tc    ? {32'h0000_0000, tcmd_q} : 64'h0000_0000_0000_0000;
	wire [63:0] read_val = is_sread ? stamp_q : (is_cread ? cread_val : msr_val);
	wire rd_any = (is_rd || is_sread || is_cread) && !deny;

	// the stamp has no gate besides the clock enable, so it runs through suspend
	assign stamp_d = (wr_ok && sel_stamp) ? wdata : stamp_q + 64'h0000_0000_0000_0001;

	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			stamp_q <= 64'h0000_0000_0000_0000;
			ctrl_q  <= cecnt_pkg::CTRL_RESET;
			tdata_q <= 32'h0000_0000;
			taddr_q <= 32'h0000_0000;
			tcmd_q  <= 32'h0000_0000;
		end
		else if (CLK_EN_I)
		begin
			stamp_q <= stamp_d;
			if (wr_ok && sel_ctrl)
				ctrl_q <= SRC_LOW_I & cecnt_pkg::CTRL_WMASK;
			if (wr_ok && sel_td)
				tdata_q <= SRC_LOW_I;
			if (wr_ok && sel_ta)
				taddr_q <= SRC_LOW_I;
			if (wr_ok && sel_tc)
				tcmd_q <= SRC_LOW_I;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cnt
			localparam int B = gi * cecnt_pkg::FLD_STRIDE;
			wire       ctype = ctrl_q[B + cecnt_pkg::FLD_TYPE];
			wire       en_lo = ctrl_q[B + cecnt_pkg::FLD_BELOW3];
			wire       en_u  = ctrl_q[B + cecnt_pkg::FLD_LEVEL3];
			wire       lvl_ok = lvl3 ? en_u : en_lo;
			wire [7:0] ev_idx = {(gi == 1), evsel(ctrl_q, gi)};
			wire       ev_hit = EVENT_HIT_I[ev_idx];
			wire       inc   = lvl_ok && (ctype || ev_hit);
			wire       wsel  = wr_ok && ((gi == 0) ? sel_c0 : sel_c1);
			always_ff @(posedge MCLK_I)
			begin
				if (SYS_RST_I)
					cnt_q[gi] <= 48'h0000_0000_0000;
				else if (CLK_EN_I)
				begin
					if (wsel)
						cnt_q[gi] <= wdata[47:0];
					else if (inc)
						cnt_q[gi] <= cnt_q[gi] + 48'h0000_0000_0001;
				end
			end
		end
	endgenerate

	always_ff @(posedge MCLK_I)
	begin
		if (SYS_RST_I)
		begin
			res_hi_q  <= 32'h0000_0000;
			res_lo_q  <= 32'h0000_0000;
			res_vld_q <= 1'b0;
			fault_q   <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			res_vld_q <= rd_any;
			fault_q   <= deny;
			if (rd_any)
			begin
				res_hi_q <= read_val[63:32];
				res_lo_q <= read_val[31:0];
			end
		end
	end

	assign RESULT_HIGH_O     = res_hi_q;
	assign RESULT_LOW_O      = res_lo_q;
	assign RESULT_VALID_O    = res_vld_q;
	assign PROT_FAULT_O      = fault_q;
	assign TEST_DATA_O       = tdata_q;
	assign TEST_ADDRESS_O    = taddr_q;
	assign TEST_CMD_STATUS_O = tcmd_q;

	// checks
	// field offset of counter one inside the control word
	localparam int C1B = cecnt_pkg::FLD_STRIDE;

	property p_stamp_inc;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !(wr_ok && sel_stamp) |=> stamp_q == $past(stamp_q) + 64'h1;
	endproperty
	a_stamp_inc: assert property (p_stamp_inc) else $error("stamp did not advance");
	c_stamp_write: cover property (@(posedge MCLK_I) CLK_EN_I && wr_ok && sel_stamp);

	property p_freeze;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		!CLK_EN_I |=> $stable(stamp_q) && $stable(ctrl_q) && $stable(cnt_q[0])
			&& $stable(cnt_q[1]) && $stable(RESULT_VALID_O) && $stable(PROT_FAULT_O);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_fault_nochange;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && deny |=> PROT_FAULT_O && !RESULT_VALID_O && $stable(ctrl_q);
	endproperty
	a_fault_nochange: assert property (p_fault_nochange) else $error("fault changed state");
	property p_msr_deny;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && (is_rd || is_wr) && !lvl0 |=> PROT_FAULT_O && !RESULT_VALID_O
			&& $stable(tdata_q) && $stable(taddr_q) && $stable(tcmd_q);
	endproperty
	a_msr_deny: assert property (p_msr_deny) else $error("register access not denied");
	property p_sread_deny;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_sread && STAMP_RESTRICT_I && !lvl0 |=> PROT_FAULT_O;
	endproperty
	a_sread_deny: assert property (p_sread_deny) else $error("stamp read not denied");
	property p_cread_deny;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_cread && !COUNTER_READ_ENABLE_I && !lvl0 |=> PROT_FAULT_O;
	endproperty
	a_cread_deny: assert property (p_cread_deny) else $error("counter read not denied");

	property p_sread;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_sread && sread_ok |=> RESULT_VALID_O
			&& {RESULT_HIGH_O, RESULT_LOW_O} == $past(stamp_q);
	endproperty
	a_sread: assert property (p_sread) else $error("stamp read wrong");
	property p_cread;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_cread && cread_ok |=> RESULT_VALID_O
			&& {RESULT_HIGH_O, RESULT_LOW_O}
			== {16'h0000, $past(INDEX_I[0] ? cnt_q[1] : cnt_q[0])};
	endproperty
	a_cread: assert property (p_cread) else $error("counter read wrong");
	property p_msr_read;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_rd && msr_ok && sel_stamp |=> RESULT_VALID_O
			&& {RESULT_HIGH_O, RESULT_LOW_O} == $past(stamp_q);
	endproperty
	a_msr_read: assert property (p_msr_read) else $error("register read wrong");
	property p_unmapped;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_rd && msr_ok && !(sel_stamp || sel_ctrl || sel_c0 || sel_c1 || sel_td
			|| sel_ta || sel_tc) |=> {RESULT_HIGH_O, RESULT_LOW_O} == 64'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_write_novalid;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && is_wr |=> !RESULT_VALID_O;
	endproperty
	a_write_novalid: assert property (p_write_novalid) else $error("write gave a result");
	c_deny: cover property (@(posedge MCLK_I) PROT_FAULT_O);
	c_cread: cover property (@(posedge MCLK_I) CLK_EN_I && is_cread && cread_ok);

	property p_ctrl_write;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && wr_ok && sel_ctrl |=> ctrl_q == ($past(SRC_LOW_I) & cecnt_pkg::CTRL_WMASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");
	property p_test_write;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && wr_ok && sel_td |=> TEST_DATA_O == $past(SRC_LOW_I);
	endproperty
	a_test_write: assert property (p_test_write) else $error("test data write lost");
	property p_cwrite;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && wr_ok && sel_c0 |=> cnt_q[0] == $past(wdata[47:0]);
	endproperty
	a_cwrite: assert property (p_cwrite) else $error("counter write lost");
	property p_c1_write;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && wr_ok && sel_c1 |=> cnt_q[1] == $past(wdata[47:0]);
	endproperty
	a_c1_write: assert property (p_c1_write) else $error("counter one write lost");
	c_wrap: cover property (@(posedge MCLK_I) cnt_q[0] == 48'hFFFF_FFFF_FFFF ##1 cnt_q[0] == 48'h0);

	property p_c0_stop;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !ctrl_q[cecnt_pkg::FLD_BELOW3] && !ctrl_q[cecnt_pkg::FLD_LEVEL3]
			&& !(wr_ok && sel_c0) |=> cnt_q[0] == $past(cnt_q[0]);
	endproperty
	a_c0_stop: assert property (p_c0_stop) else $error("counter zero ran while disabled");
	property p_c1_stop;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !ctrl_q[C1B + cecnt_pkg::FLD_BELOW3] && !ctrl_q[C1B + cecnt_pkg::FLD_LEVEL3]
			&& !(wr_ok && sel_c1) |=> cnt_q[1] == $past(cnt_q[1]);
	endproperty
	a_c1_stop: assert property (p_c1_stop) else $error("counter one ran while disabled");
	property p_c0_level3;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && lvl3 && !ctrl_q[cecnt_pkg::FLD_LEVEL3] && !(wr_ok && sel_c0)
			|=> cnt_q[0] == $past(cnt_q[0]);
	endproperty
	a_c0_level3: assert property (p_c0_level3) else $error("counter zero ran at level 3");
	property p_c1_timer;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && ctrl_q[C1B + cecnt_pkg::FLD_TYPE] && ctrl_q[C1B + cecnt_pkg::FLD_BELOW3]
			&& ctrl_q[C1B + cecnt_pkg::FLD_LEVEL3] && !(wr_ok && sel_c1)
			|=> cnt_q[1] == $past(cnt_q[1]) + 48'h1;
	endproperty
	a_c1_timer: assert property (p_c1_timer) else $error("counter one timer missed");
	property p_c0_event;
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !ctrl_q[cecnt_pkg::FLD_TYPE] && ctrl_q[cecnt_pkg::FLD_BELOW3] && !lvl3
			&& EVENT_HIT_I[{1'b0, evsel(ctrl_q, 0)}] && !(wr_ok && sel_c0)
			|=> cnt_q[0] == $past(cnt_q[0]) + 48'h1;
	endproperty
	a_c0_event: assert property (p_c0_event) else $error("counter zero event missed");
endmodule
